// ### acc_params.svh
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define ACC_IDX_CHAN_BASE 14'h080c
`define ACC_IDX_CHAN_LAST 14'h0813
`define ACC_IDX_MIRROR    14'h081f
`define ACC_IDX_INT_FLAG  14'h0820
`define ACC_IDX_INT_MASK  14'h0821
`define ACC_IDX_GIE       14'h0822

// ==========================================================
// Field positions
`define ACC_CON0_EN   7
`define ACC_CON0_OUT  6
`define ACC_CON0_POL  4
`define ACC_CON0_HYS  1
`define ACC_CON0_SYNC 0
`define ACC_CON1_RISE 1
`define ACC_CON1_FALL 0
`define ACC_GIE_BIT   0

// ==========================================================
// Source select codes and reset values
`define ACC_NCH_NC    3'h4
`define ACC_PCH_NC_LO 3'h1
`define ACC_PCH_NC_HI 3'h3
`define ACC_SEL_RESET 3'h0
`define ACC_BIT_RESET 1'h0

// ==========================================================
// Bus answers
`define ACC_RESP_OKAY   2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// ### acc_pkg.sv
package acc_pkg;
   `include "acc_params.svh"

   typedef enum logic [2:0] {
      ACC_K_CON0   = 3'h0,
      ACC_K_CON1   = 3'h1,
      ACC_K_NCH    = 3'h2,
      ACC_K_PCH    = 3'h3,
      ACC_K_MIRROR = 3'h4,
      ACC_K_FLAG   = 3'h5,
      ACC_K_MASK   = 3'h6,
      ACC_K_GIE    = 3'h7
   } acc_kind_e;

   typedef struct packed {
      logic      hit;
      logic      chan;
      acc_kind_e kind;
   } acc_sel_s;

   typedef struct packed {
      logic [1:0]      en;
      logic [1:0]      output_invert;
      logic [1:0]      hysteresis_enable;
      logic [1:0]      sync;
      logic [1:0]      rise_en;
      logic [1:0]      fall_en;
      logic [1:0][2:0] negative_source_select;
      logic [1:0][2:0] positive_source_select;
      logic [1:0]      flag;
      logic [1:0]      mask;
      logic            global_int_enable;
      logic [1:0]      raw_s1;
      logic [1:0]      raw_s2;
      logic [1:0]      out;
      logic            tmr_s1;
      logic            tmr_s2;
      logic            tmr_s3;
      logic            aw_got;
      logic            w_got;
      logic [15:0]     awaddr;
      logic [7:0]      wdata;
      logic            wstb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [7:0]      rdata;
      logic [1:0]      rresp;
   } acc_state_s;

   typedef struct packed {
      logic prev;
   } acc_edge_s;

   typedef struct packed {
      logic held;
   } acc_cap_s;
endpackage

// ### acc_edge_detect.sv
module acc_edge_detect
   import acc_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic out_now,
   input  wire logic rise_int_enable,
   input  wire logic fall_int_enable,
   output logic      edge_hit
);
   acc_edge_s s_q;
   acc_edge_s s_d;

   // ==========================================================
   // Edge detection on the latched, polarity-adjusted output
   always_comb
   begin
      s_d      = s_q;
      s_d.prev = out_now;
      edge_hit = (out_now & ~s_q.prev & rise_int_enable)
               | (~out_now & s_q.prev & fall_int_enable);
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule

// ### acc_sync_capture.sv
module acc_sync_capture
   import acc_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic tmr_fall,
   input  wire logic sync_sel,
   input  wire logic d,
   output logic      ext_out
);
   acc_cap_s s_q;
   acc_cap_s s_d;

   // ==========================================================
   // Capture on timer clock falling edge, else pass through
   always_comb
   begin
      s_d = s_q;
      if (tmr_fall)
      begin
         s_d.held = d;
      end
      ext_out = sync_sel ? s_q.held : d;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule

// ### acc_top.sv
// Behaviour
// - Raw result high when plus exceeds minus
// - Disabled: inputs disconnected, result gated to 0 before output_invert
// - Enable bit powers comparator on or off
// - output_invert complements the reported result
// - Per-channel bit plus all_outputs_mirror readback
// - Internal output latched; pin output unlatched
// - Sync mode captures on timer falling edge
// - Timer clock taken after the prescaler
// - Falling capture avoids race with counter
// - hysteresis_enable switches input hysteresis
// - Enabled rising or falling edge sets flag
// - Flag sticky until software clears it
// - Inverting while disabled can raise interrupt
// - Positive select routes source; off disconnects
// - Negative select routes pin, reference, ground
// - Negative codes: 100 unconnected, others routed
// - Positive codes: 001 to 011 unconnected
module acc_top
   import acc_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            nrst,
   // AXI4-Lite slave
   input  wire logic [15:0]     s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [15:0]     s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   // Analog core and timer
   input  wire logic [1:0]      cmp_raw,
   input  wire logic            tmr_clk_post_prescale,
   output logic [1:0]           cmp_power_en,
   output logic [1:0]           hysteresis_on,
   output logic [1:0][2:0]      pos_source,
   output logic [1:0][2:0]      neg_source,
   output logic [1:0]           pos_connect,
   output logic [1:0]           neg_connect,
   output logic [1:0]           cmp_ext_out,
   output logic                 irq
);
   acc_state_s s_q;
   acc_state_s s_d;
   logic [1:0] adj_now;
   logic [1:0] edge_hit;
   logic       tmr_fall;

   // ==========================================================
   // Address decode shared by read and write paths
   function automatic acc_sel_s decode(input logic [15:0] a);
      acc_sel_s   r;
      logic [13:0] idx;
      logic [13:0] off;
      r   = '0;
      idx = a[15:2];
      off = idx - `ACC_IDX_CHAN_BASE;
      // Unaligned addresses never hit and so answer with an error
      if (a[1:0] == 2'h0)
      begin
         // Four registers per comparator, channel in offset bit 2
         if (idx >= `ACC_IDX_CHAN_BASE && idx <= `ACC_IDX_CHAN_LAST)
         begin
            r.hit  = 1'b1;
            r.chan = off[2];
            r.kind = acc_kind_e'({1'b0, off[1:0]});
         end
         else if (idx == `ACC_IDX_MIRROR)
         begin
            r.hit  = 1'b1;
            r.kind = ACC_K_MIRROR;
         end
         else if (idx == `ACC_IDX_INT_FLAG)
         begin
            r.hit  = 1'b1;
            r.kind = ACC_K_FLAG;
         end
         else if (idx == `ACC_IDX_INT_MASK)
         begin
            r.hit  = 1'b1;
            r.kind = ACC_K_MASK;
         end
         else if (idx == `ACC_IDX_GIE)
         begin
            r.hit  = 1'b1;
            r.kind = ACC_K_GIE;
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Register read mux
   function automatic logic [7:0] read_reg(input acc_sel_s sel, input acc_state_s st);
      logic [7:0] v;
      v = 8'h00;
      // Reserved bits stay zero
      case (sel.kind)
         ACC_K_CON0:
         begin
            v[`ACC_CON0_EN]   = st.en[sel.chan];
            v[`ACC_CON0_OUT]  = st.out[sel.chan];
            v[`ACC_CON0_POL]  = st.output_invert[sel.chan];
            v[`ACC_CON0_HYS]  = st.hysteresis_enable[sel.chan];
            v[`ACC_CON0_SYNC] = st.sync[sel.chan];
         end
         ACC_K_CON1:
         begin
            v[`ACC_CON1_RISE] = st.rise_en[sel.chan];
            v[`ACC_CON1_FALL] = st.fall_en[sel.chan];
         end
         ACC_K_NCH:    v[2:0] = st.negative_source_select[sel.chan];
         ACC_K_PCH:    v[2:0] = st.positive_source_select[sel.chan];
         ACC_K_MIRROR: v[1:0] = st.out;
         ACC_K_FLAG:   v[1:0] = st.flag;
         ACC_K_MASK:   v[1:0] = st.mask;
         ACC_K_GIE:    v[`ACC_GIE_BIT] = st.global_int_enable;
         default:      v = 8'h00;
      endcase
      return v;
   endfunction

   // ==========================================================
   // Source codes that leave an input open
   function automatic logic pch_open(input logic [2:0] code);
      return (code >= `ACC_PCH_NC_LO) && (code <= `ACC_PCH_NC_HI);
   endfunction

   function automatic logic nch_open(input logic [2:0] code);
      return code == `ACC_NCH_NC;
   endfunction

   // ==========================================================
   // Per-channel edge detection and timer-synchronised output
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_chan
         // Reads the latched output so that one transition flags once
         acc_edge_detect u_edge (
            .clk             (clk),
            .nrst            (nrst),
            .out_now         (s_q.out[g]),
            .rise_int_enable (s_q.rise_en[g]),
            .fall_int_enable (s_q.fall_en[g]),
            .edge_hit        (edge_hit[g])
         );
         acc_sync_capture u_cap (
            .clk      (clk),
            .nrst     (nrst),
            .tmr_fall (tmr_fall),
            .sync_sel (s_q.sync[g]),
            .d        (adj_now[g]),
            .ext_out  (cmp_ext_out[g])
         );
      end
   endgenerate

   // ==========================================================
   // Output path: gate, invert
   always_comb
   begin
      // Gating comes before inversion, so inverting a disabled channel moves the output
      adj_now = (s_q.en & s_q.raw_s2) ^ s_q.output_invert;
   end

   // ==========================================================
   // Falling edge of the synchronised timer clock
   always_comb
   begin
      tmr_fall = s_q.tmr_s3 & ~s_q.tmr_s2;
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      acc_sel_s    wsel;
      acc_sel_s    rsel;
      logic        aw_take;
      logic        w_take;
      logic        ar_take;
      logic        have_aw;
      logic        have_w;
      logic [15:0] waddr;
      logic [7:0]  wd;
      logic        wst;
      logic [1:0]  clr;
      wsel    = '0;
      rsel    = '0;
      clr     = 2'h0;
      aw_take = 1'b0;
      w_take  = 1'b0;
      ar_take = 1'b0;
      have_aw = 1'b0;
      have_w  = 1'b0;
      waddr   = 16'h0000;
      wd      = 8'h00;
      wst     = 1'b0;
      s_d     = s_q;

      // A pending answer blocks new items on its channel
      s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
      s_axi_wready  = ~s_q.w_got & ~s_q.bvalid;
      s_axi_arready = ~s_q.rvalid;
      aw_take = s_axi_awvalid & s_axi_awready;
      w_take  = s_axi_wvalid & s_axi_wready;
      ar_take = s_axi_arvalid & s_axi_arready;

      // Input synchronisers
      s_d.raw_s1 = cmp_raw;
      s_d.raw_s2 = s_q.raw_s1;
      s_d.tmr_s1 = tmr_clk_post_prescale;
      s_d.tmr_s2 = s_q.tmr_s1;
      s_d.tmr_s3 = s_q.tmr_s2;

      // Internal output latched every cycle
      s_d.out = adj_now;

      // Write channel: address and data in either order
      if (aw_take)
      begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (w_take)
      begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata[7:0];
         s_d.wstb  = s_axi_wstrb[0];
      end
      have_aw = s_q.aw_got | aw_take;
      have_w  = s_q.w_got | w_take;
      waddr   = aw_take ? s_axi_awaddr : s_q.awaddr;
      wd      = w_take ? s_axi_wdata[7:0] : s_q.wdata;
      wst     = w_take ? s_axi_wstrb[0] : s_q.wstb;

      // Commit once both halves are in and the last answer has gone
      if (have_aw && have_w && !s_q.bvalid)
      begin
         wsel       = decode(waddr);
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = wsel.hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
         // A cleared strobe answers OKAY but writes nothing
         if (wsel.hit && wst)
         begin
            case (wsel.kind)
               ACC_K_CON0:
               begin
                  s_d.en[wsel.chan]   = wd[`ACC_CON0_EN];
                  s_d.output_invert[wsel.chan]  = wd[`ACC_CON0_POL];
                  s_d.hysteresis_enable[wsel.chan]  = wd[`ACC_CON0_HYS];
                  s_d.sync[wsel.chan] = wd[`ACC_CON0_SYNC];
               end
               ACC_K_CON1:
               begin
                  s_d.rise_en[wsel.chan] = wd[`ACC_CON1_RISE];
                  s_d.fall_en[wsel.chan] = wd[`ACC_CON1_FALL];
               end
               ACC_K_NCH:  s_d.negative_source_select[wsel.chan] = wd[2:0];
               ACC_K_PCH:  s_d.positive_source_select[wsel.chan] = wd[2:0];
               ACC_K_FLAG: clr = wd[1:0];
               ACC_K_MASK: s_d.mask = wd[1:0];
               ACC_K_GIE:  s_d.global_int_enable = wd[`ACC_GIE_BIT];
               default:    clr = 2'h0;
            endcase
         end
      end
      if (s_q.bvalid && s_axi_bready)
      begin
         s_d.bvalid = 1'b0;
      end

      // Sticky flags; a new edge beats a clear in the same cycle
      s_d.flag = (s_q.flag & ~clr) | edge_hit;

      // Read channel
      // Read data come from the current state, before a same-cycle write lands
      if (ar_take)
      begin
         rsel       = decode(s_axi_araddr);
         s_d.rvalid = 1'b1;
         s_d.rdata  = rsel.hit ? read_reg(rsel, s_q) : 8'h00;
         s_d.rresp  = rsel.hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end
      if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk)
   begin
      if (!nrst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // ==========================================================
   // Bus outputs
   always_comb
   begin
      s_axi_bvalid = s_q.bvalid;
      s_axi_bresp  = s_q.bresp;
      s_axi_rvalid = s_q.rvalid;
      s_axi_rresp  = s_q.rresp;
      s_axi_rdata  = {24'h000000, s_q.rdata};
   end

   // ==========================================================
   // Analog control and interrupt outputs
   always_comb
   begin
      cmp_power_en  = s_q.en;
      hysteresis_on = s_q.hysteresis_enable;
      pos_source    = s_q.positive_source_select;
      neg_source    = s_q.negative_source_select;
      irq           = s_q.global_int_enable & |(s_q.flag & s_q.mask);
      for (int i = 0; i < 2; i++)
      begin
         pos_connect[i] = s_q.en[i] & ~pch_open(s_q.positive_source_select[i]);
         neg_connect[i] = s_q.en[i] & ~nch_open(s_q.negative_source_select[i]);
      end
   end
endmodule

// ### acc_checker_assertions.sv
// ==========================================
// Port checks for the comparator control top
module acc_checker
   import acc_pkg::*;
(
   input wire logic            clk,
   input wire logic            nrst,
   input wire logic            s_axi_awvalid,
   input wire logic            s_axi_awready,
   input wire logic            s_axi_wvalid,
   input wire logic            s_axi_wready,
   input wire logic            s_axi_bvalid,
   input wire logic            s_axi_bready,
   input wire logic [1:0]      s_axi_bresp,
   input wire logic            s_axi_arvalid,
   input wire logic            s_axi_arready,
   input wire logic            s_axi_rvalid,
   input wire logic            s_axi_rready,
   input wire logic [31:0]     s_axi_rdata,
   input wire logic [1:0]      cmp_power_en,
   input wire logic [1:0]      hysteresis_on,
   input wire logic [1:0][2:0] pos_source,
   input wire logic [1:0][2:0] neg_source,
   input wire logic [1:0]      pos_connect,
   input wire logic [1:0]      neg_connect,
   input wire logic            irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   property p_conn_off;
      ((pos_connect | neg_connect) & ~cmp_power_en) == 2'h0;
   endproperty
   a_conn_off: assert property (p_conn_off)
      else $error("input connected while off");
   property p_neg_map;
      neg_connect == (cmp_power_en & {neg_source[1] != 3'h4, neg_source[0] != 3'h4});
   endproperty
   a_neg_map: assert property (p_neg_map) else $error("negative connect wrong");
   property p_pos_map;
      pos_connect == (cmp_power_en & {pos_source[1] == 3'h0 || pos_source[1] > 3'h3,
                                      pos_source[0] == 3'h0 || pos_source[0] > 3'h3});
   endproperty
   a_pos_map: assert property (p_pos_map) else $error("positive connect wrong");
   property p_cfg_write;
      $changed({cmp_power_en, hysteresis_on, pos_source, neg_source}) |-> $rose(s_axi_bvalid);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("config moved without write");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
   property p_ar_busy;
      s_axi_arready == !s_axi_rvalid;
   endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read address ready wrong");
   property p_w_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
   endproperty
   a_w_ans: assert property (p_w_ans) else $error("write answer late");
   property p_r_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_ans: assert property (p_r_ans) else $error("read answer late");

   c_irq_up: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_all_conn: cover property (&pos_connect && &neg_connect);
endmodule

bind acc_top acc_checker u_chk (.*);

// ### acc_analog_model.sv
// ==========================================
// Analog core and timer clock stand-in
module acc_analog_model
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [1:0] power_en,
   input  wire logic [1:0] pos_conn,
   input  wire logic [1:0] neg_conn,
   input  wire logic [1:0] decision,
   input  wire logic       tmr_run,
   output logic      [1:0] raw,
   output logic            tmr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] live;
   logic [1:0] junk_q;
   logic [2:0] cnt_q;

   assign live = power_en & pos_conn & neg_conn;
   // Unpowered or open inputs wander instead of holding a level
   assign raw = (live & decision) | (~live & junk_q);
   // Timer clock idles high and runs only on request
   assign tmr = ~cnt_q[2];
   always_ff @(posedge clk)
   begin
      junk_q <= nrst ? ~junk_q : 2'h0;
      cnt_q  <= tmr_run ? cnt_q + 3'h1 : 3'h0;
   end
endmodule

// ### tb_top.sv
`include "acc_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clk, nrst, irq, tmr_clk_post_prescale, tmr_run;
   logic [15:0]     s_axi_awaddr, s_axi_araddr, lf;
   logic [31:0]     s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]      s_axi_wstrb;
   logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic            s_axi_rvalid, s_axi_rready;
   logic [1:0]      s_axi_bresp, s_axi_rresp, cmp_raw, cmp_power_en, hysteresis_on;
   logic [1:0]      pos_connect, neg_connect, cmp_ext_out, decision, resp;
   logic [1:0][2:0] pos_source, neg_source;
   int              miscompares, compares;

   acc_top u_dut (.*);
   acc_analog_model u_model (.clk(clk), .nrst(nrst), .power_en(cmp_power_en),
      .pos_conn(pos_connect), .neg_conn(neg_connect), .decision(decision),
      .tmr_run(tmr_run), .raw(cmp_raw), .tmr(tmr_clk_post_prescale));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic finish_test;
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 60)
      begin
         chk("timeout", 34'h0, 34'h1);
         finish_test();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         tick(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         tick(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
   endtask
   function automatic logic [15:0] ia(input logic [13:0] idx);
      return {idx, 2'b00};
   endfunction
   function automatic logic [15:0] ra(input int ch, input int k);
      return ia(`ACC_IDX_CHAN_BASE) + 16'(ch * 16 + k * 4);
   endfunction
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [7:0] exp_con0(input logic output_invert, input logic dec, input logic hysteresis_enable);
      return {1'b1, dec ^ output_invert, 1'b0, output_invert, 2'h0, hysteresis_enable, 1'b0};
   endfunction

   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      {nrst, tmr_run, decision} = '0;
      lf = 16'h33b1;
      miscompares = 0;
      compares = 0;
      cyc(12);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         rd(ra(i / 4, i % 4));
         chk("reset_value", 34'h0, {resp, rdat});
      end
      rd(16'h0000);
      chk("unmapped_rd", {2'h2, 32'h0}, {resp, rdat});
      wr(ia(14'h0814), 8'hff);
      chk("unmapped_wr", 34'h2, 34'(resp));
      wr(ra(0, 0), 8'h80);
      wr(ra(1, 0), 8'h80);
      for (int c = 0; c < 8; c++)
      begin
         wr(ra(0, 3), 8'(c));
         wr(ra(1, 2), 8'(c));
         chk("pos_source", 34'(c), 34'(pos_source[0]));
         chk("pos_connect", 34'(c == 0 || c > 3), 34'(pos_connect[0]));
         chk("neg_connect", 34'(c != 4), 34'(neg_connect[1]));
         chk("neg_source", 34'(c), 34'(neg_source[1]));
         rd(ra(1, 2));
         chk("neg_select", 34'(c), {resp, rdat});
      end
      wr(ra(0, 3), 8'h00);
      wr(ra(1, 2), 8'h00);
      for (int i = 0; i < 12; i++)
      begin
         lf = nx(lf);
         for (int ch = 0; ch < 2; ch++) wr(ra(ch, 0), {3'h4, lf[ch], 2'h0, lf[ch + 2], 1'b0});
         decision <= lf[5:4];
         cyc(6);
         rd(ia(`ACC_IDX_MIRROR));
         chk("mirror", 34'(lf[5:4] ^ lf[1:0]), {resp, rdat});
         chk("hysteresis", 34'(lf[3:2]), 34'(hysteresis_on));
         rd(ra(0, 0));
         chk("out_bit", 34'(exp_con0(lf[0], lf[4], lf[2])), {resp, rdat});
      end
      wr(ra(0, 0), 8'h00);
      decision <= 2'h1;
      cyc(6);
      rd(ia(`ACC_IDX_MIRROR));
      chk("disabled_out", 34'({lf[1], 1'b0}), {resp, rdat});
      chk("power", 34'h4, 34'({cmp_power_en, pos_connect[0]}));
      wr(ra(0, 1), 8'h02);
      wr(ia(`ACC_IDX_INT_MASK), 8'h03);
      wr(ia(`ACC_IDX_GIE), 8'h01);
      wr(ra(0, 0), 8'h10);
      cyc(3);
      chk("irq_invert", 34'h1, 34'(irq));
      wr(ia(`ACC_IDX_INT_FLAG), 8'h01);
      chk("irq_cleared", 34'h0, 34'(irq));
      wr(ra(0, 1), 8'h01);
      wr(ra(0, 0), 8'h00);
      cyc(3);
      chk("irq_fall", 34'h1, 34'(irq));
      wr(ia(`ACC_IDX_GIE), 8'h00);
      chk("irq_gie_off", 34'h0, 34'(irq));
      rd(ia(`ACC_IDX_INT_FLAG));
      chk("flag_sticky", 34'h1, {resp, rdat});
      wr(ia(`ACC_IDX_INT_FLAG), 8'h03);
      wr(ra(1, 0), 8'h80);
      wr(ra(1, 1), 8'h02);
      decision <= 2'h2;
      cyc(6);
      rd(ia(`ACC_IDX_INT_FLAG));
      chk("flag_rise", 34'h2, {resp, rdat});
      wr(ra(0, 0), 8'h81);
      decision <= 2'h1;
      cyc(8);
      chk("sync_hold", 34'h0, 34'(cmp_ext_out[0]));
      tmr_run <= 1'b1;
      cyc(16);
      tmr_run <= 1'b0;
      chk("sync_capture", 34'h1, 34'(cmp_ext_out[0]));
      wr(ra(0, 0), 8'h80);
      decision <= 2'h0;
      cyc(6);
      chk("async_out", 34'h0, 34'(cmp_ext_out[0]));
      finish_test();
   end
endmodule
